// >>> sdc_pkg.sv
/*
  Shared constants, command and pin types for the bank sequencer.
  Assumes one 20 MHz clock shared with the memory controller.
*/
package sdc_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int TWR_NS        = 15;
  localparam int TWR_CYC_RAW   = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_CYC       = (TWR_CYC_RAW < 1) ? 1 : TWR_CYC_RAW;
  localparam int TWR_W         = 4;

  localparam int NBANK  = 4;
  localparam int BA_W   = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W  = 8;
  localparam int DQ_W   = 16;
  localparam int DQM_W  = 2;
  localparam int LEN_W  = 9;

  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam int AP_BIT      = 10;

  localparam logic [11:0] MODE_RST = 12'h020;
  localparam logic [2:0]  BL_1     = 3'h0;
  localparam logic [2:0]  BL_2     = 3'h1;
  localparam logic [2:0]  BL_4     = 3'h2;
  localparam logic [2:0]  BL_8     = 3'h3;
  localparam logic [2:0]  BL_PAGE  = 3'h7;
  localparam logic [2:0]  CL_3     = 3'h3;
  localparam logic [8:0]  LEN_PAGE = 9'h100;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LMR, CMD_BST
  } sdc_cmd_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [DQM_W-1:0]  dqm;
  } sdc_pins_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [BA_W-1:0]   bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [DQ_W-1:0]   wdata;
    logic [DQM_W-1:0]  wmask;
  } sdc_acc_t;

  function automatic logic [8:0] burst_len(input logic [2:0] code);
    unique case (code)
      BL_1:    burst_len = 9'h001;
      BL_2:    burst_len = 9'h002;
      BL_4:    burst_len = 9'h004;
      BL_8:    burst_len = 9'h008;
      default: burst_len = LEN_PAGE;
    endcase
  endfunction

endpackage

// >>> sdc_colgen.sv
/*
  Column generator: column of beat idx within a burst.
  Assumes the start column and beat index come from the sequencer.
*/
`timescale 1ns/100ps
module sdc_colgen (
  input  wire logic [7:0] i_start,
  input  wire logic [7:0] i_idx,
  input  wire logic [2:0] i_bl,
  input  wire logic       i_ilv,
  output logic      [7:0] o_col
);
  logic [8:0] len;
  logic [7:0] mask;
  logic [7:0] low;

  always_comb begin
    len   = sdc_pkg::burst_len(i_bl);
    mask  = len[7:0] - 8'h01;
    low   = i_ilv ? (i_start ^ i_idx) : (i_start + i_idx);
    // Wrap inside the burst block, a full page wraps over all columns
    o_col = (i_start & ~mask) | (low & mask);
  end
endmodule

// >>> sdc_bank.sv
/*
  One bank: open/idle state, pending auto precharge and write recovery.
  Assumes the sequencer gives one-cycle command pulses for this bank.
*/
`timescale 1ns/100ps
module sdc_bank (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_act,
  input  wire logic        i_pre,
  input  wire logic        i_ap_set,
  input  wire logic        i_ap_now,
  input  wire logic        i_ap_twr,
  output logic             o_open,
  output logic             o_ap_pend,
  output logic             o_pre_start
);
  typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_RECOVER} sdc_bank_st_t;

  sdc_bank_st_t                    state;
  logic [sdc_pkg::TWR_W-1:0]       twr_cnt;
  localparam logic [sdc_pkg::TWR_W-1:0] TWR_LOAD = sdc_pkg::TWR_W'(sdc_pkg::TWR_CYC);

  assign o_open      = (state != BK_IDLE);
  assign o_pre_start = (i_pre && o_open)
                     || (i_ap_now && o_ap_pend)
                     || (state == BK_RECOVER && twr_cnt == 4'h1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= BK_IDLE;
    end else if (o_pre_start && !i_ap_set) begin
      state <= BK_IDLE;
    end else if (i_act && state == BK_IDLE) begin
      state <= BK_OPEN;
    end else if (i_ap_twr && o_ap_pend) begin
      state <= BK_RECOVER;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      twr_cnt <= '0;
    end else if (i_ap_twr) begin
      twr_cnt <= TWR_LOAD;
    end else if (twr_cnt != '0) begin
      twr_cnt <= twr_cnt - 4'h1;
    end
  end

  // Set wins over the clear of a precharge in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ap_pend <= 1'b0;
    end else if (i_ap_set) begin
      o_ap_pend <= 1'b1;
    end else if (o_pre_start) begin
      o_ap_pend <= 1'b0;
    end
  end

  property p_ap_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_ap_pend && o_pre_start && !i_ap_set) |=> !o_ap_pend ##1 (!o_open || i_act);
  endproperty
  a_ap_clear: assert property (p_ap_clear) else $error("ap flag not cleared at precharge");
endmodule

// >>> sdc_core.sv
/*
  Command sequencer of a four-bank synchronous DRAM: mode register,
  bank states, burst engine and concurrent auto precharge.
  Assumes the controller drives pins on the same clock, so no
  synchroniser is used, and a storage array answers reads in the
  cycle of the access.
*/
// Function
// - With write burst mode bit set, each WRITE touches one column only.
// - READs always follow the programmed burst length and sequence.
// - READ or WRITE to another bank is accepted during an auto-precharge access.
// - READ to bank m cuts bank n READ; output switches one CAS latency later.
// - That interrupted auto-precharge READ starts bank n precharge at once.
// - WRITE cuts an auto-precharge READ at once and starts its precharge.
// - READ interrupting auto-precharge WRITE: precharge after write recovery from READ.
// - Last data written then is the one sampled a clock before the READ.
// - WRITE interrupting auto-precharge WRITE: precharge after write recovery.
// - Last data stored then is the one registered a clock before that WRITE.
// - Chip select high at a clock edge makes any command a no-operation.
// - Data outputs are high impedance after initialization commands.
// - A precharged bank is idle and needs an activate before any access.
`timescale 1ns/100ps
module sdc_core (
  input  wire logic                  I_MCLK,
  input  wire logic                  I_RST_N,
  input  wire sdc_pkg::sdc_pins_t    I_PINS,
  input  wire logic [15:0]           I_DQ,
  input  wire logic [15:0]           I_ACC_RDATA,
  output sdc_pkg::sdc_acc_t          O_ACC,
  output logic [15:0]                O_DQ,
  output logic [1:0]                 O_DQ_OE,
  output logic [3:0]                 O_BANK_OPEN,
  output logic [3:0]                 O_AP_PEND,
  output logic [3:0]                 O_PRE_START
);
  localparam int TWR_D = sdc_pkg::TWR_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and mode register

  sdc_pkg::sdc_cmd_t cmd;
  logic [11:0]       mode;
  logic [11:0]       row [4];
  logic [2:0]        bl_code;
  logic              ilv;
  logic              cl3;
  logic              wb_single;

  always_comb begin
    cmd = sdc_pkg::CMD_NOP;
    if (!I_PINS.cs_n) begin
      unique case ({I_PINS.ras_n, I_PINS.cas_n, I_PINS.we_n})
        3'h3:    cmd = sdc_pkg::CMD_ACT;
        3'h5:    cmd = sdc_pkg::CMD_RD;
        3'h4:    cmd = sdc_pkg::CMD_WR;
        3'h2:    cmd = sdc_pkg::CMD_PRE;
        3'h1:    cmd = sdc_pkg::CMD_REF;
        3'h0:    cmd = sdc_pkg::CMD_LMR;
        3'h6:    cmd = sdc_pkg::CMD_BST;
        default: cmd = sdc_pkg::CMD_NOP;
      endcase
    end
  end

  assign bl_code   = mode[sdc_pkg::MODE_BL_LSB +: 3];
  assign ilv       = mode[sdc_pkg::MODE_BT_BIT];
  assign cl3       = (mode[sdc_pkg::MODE_CL_LSB +: 3] == sdc_pkg::CL_3);
  assign wb_single = mode[sdc_pkg::MODE_WB_BIT];

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode <= sdc_pkg::MODE_RST;
    end else if (cmd == sdc_pkg::CMD_LMR) begin
      mode <= I_PINS.addr;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (cmd == sdc_pkg::CMD_ACT && !O_BANK_OPEN[I_PINS.ba]) begin
      row[I_PINS.ba] <= I_PINS.addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine

  logic       bst_act;
  logic       bst_wr;
  logic       bst_ap;
  logic [1:0] bst_bank;
  logic [7:0] bst_start;
  logic [8:0] bst_idx;
  logic [8:0] bst_len;
  logic       new_rd;
  logic       new_wr;
  logic       new_acc;
  logic       cmd_ap;
  logic       stop_bst;
  logic       kill_out;
  logic       other_ap;
  logic [8:0] new_len;
  logic [8:0] next_idx;
  logic [7:0] cur_col;
  logic [3:0] ap_set;
  logic [3:0] ap_now;
  logic [3:0] twr_by_rd;
  logic [3:0] twr_by_wr;
  logic [3:0] pre_cmd;
  logic [3:0] act_cmd;

  // Idle banks ignore column commands until activated
  assign new_rd   = (cmd == sdc_pkg::CMD_RD) && O_BANK_OPEN[I_PINS.ba];
  assign new_wr   = (cmd == sdc_pkg::CMD_WR) && O_BANK_OPEN[I_PINS.ba];
  assign new_acc  = new_rd || new_wr;
  assign cmd_ap   = I_PINS.addr[sdc_pkg::AP_BIT];
  assign other_ap = bst_act && bst_ap && (bst_bank != I_PINS.ba);
  assign stop_bst = (cmd == sdc_pkg::CMD_BST)
                 || (cmd == sdc_pkg::CMD_PRE && (cmd_ap || I_PINS.ba == bst_bank));
  assign kill_out = new_wr || cmd == sdc_pkg::CMD_LMR || cmd == sdc_pkg::CMD_REF;
  assign new_len  = (new_wr && wb_single) ? 9'h001 : sdc_pkg::burst_len(bl_code);
  assign next_idx = (new_acc ? 9'h000 : bst_idx) + 9'h001;

  sdc_colgen u_colgen (
    .i_start (new_acc ? I_PINS.addr[7:0] : bst_start),
    .i_idx   (new_acc ? 8'h00 : bst_idx[7:0]),
    .i_bl    (bl_code),
    .i_ilv   (ilv),
    .o_col   (cur_col)
  );

  always_comb begin
    ap_set    = '0;
    ap_now    = '0;
    twr_by_rd = '0;
    twr_by_wr = '0;
    pre_cmd   = '0;
    act_cmd   = '0;
    if (new_acc && cmd_ap) begin
      ap_set[I_PINS.ba] = 1'b1;
    end
    if (new_acc && other_ap) begin
      if (!bst_wr) begin
        ap_now[bst_bank] = 1'b1;
      end else if (new_rd) begin
        twr_by_rd[bst_bank] = 1'b1;
      end else begin
        twr_by_wr[bst_bank] = 1'b1;
      end
    end else if (bst_act && bst_ap && !new_acc && !stop_bst && next_idx == bst_len
                 && bst_len != sdc_pkg::LEN_PAGE) begin
      if (bst_wr) begin
        twr_by_wr[bst_bank] = 1'b1;
      end else begin
        ap_now[bst_bank] = 1'b1;
      end
    end
    if (cmd == sdc_pkg::CMD_PRE) begin
      pre_cmd = cmd_ap ? 4'hF : (4'h1 << I_PINS.ba);
    end
    if (cmd == sdc_pkg::CMD_ACT) begin
      act_cmd = 4'h1 << I_PINS.ba;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bst_act   <= 1'b0;
      bst_wr    <= 1'b0;
      bst_ap    <= 1'b0;
      bst_bank  <= '0;
      bst_start <= '0;
      bst_idx   <= '0;
      bst_len   <= '0;
    end else if (new_acc) begin
      // A new access replaces the running burst at once
      bst_act   <= (new_len != 9'h001);
      bst_wr    <= new_wr;
      bst_ap    <= cmd_ap;
      bst_bank  <= I_PINS.ba;
      bst_start <= I_PINS.addr[7:0];
      bst_idx   <= 9'h001;
      bst_len   <= new_len;
    end else if (stop_bst) begin
      bst_act   <= 1'b0;
    end else if (bst_act) begin
      bst_idx   <= next_idx;
      bst_act   <= (bst_len == sdc_pkg::LEN_PAGE) || (next_idx != bst_len);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage access, one cycle after the pins

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ACC <= '0;
    end else begin
      // Old write beat of this cycle is dropped when a new READ or WRITE, a BURST TERMINATE or a precharge of its bank lands
      O_ACC.wr    <= new_wr || (bst_act && bst_wr && !new_rd && !stop_bst);
      O_ACC.rd    <= new_rd || (bst_act && !bst_wr && !new_wr && !stop_bst);
      O_ACC.bank  <= new_acc ? I_PINS.ba : bst_bank;
      O_ACC.row   <= row[new_acc ? I_PINS.ba : bst_bank];
      O_ACC.col   <= cur_col;
      O_ACC.wdata <= I_DQ;
      O_ACC.wmask <= I_PINS.dqm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data pipe; output mask lags the pins by two clocks

  logic [15:0] rd_q;
  logic        rdv_q;
  logic [1:0]  dqm_q;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_q    <= '0;
      rdv_q   <= 1'b0;
      dqm_q   <= '0;
      O_DQ    <= '0;
      O_DQ_OE <= '0;
    end else begin
      dqm_q <= I_PINS.dqm;
      rd_q  <= I_ACC_RDATA;
      rdv_q <= O_ACC.rd && !kill_out;
      O_DQ  <= cl3 ? rd_q : I_ACC_RDATA;
      if (kill_out) begin
        O_DQ_OE <= '0;
      end else begin
        O_DQ_OE <= {2{cl3 ? rdv_q : O_ACC.rd}} & ~dqm_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Banks

  for (genvar b = 0; b < 4; b++) begin : g_bank
    sdc_bank u_bank (
      .i_clk       (I_MCLK),
      .i_rst_n     (I_RST_N),
      .i_act       (act_cmd[b]),
      .i_pre       (pre_cmd[b]),
      .i_ap_set    (ap_set[b]),
      .i_ap_now    (ap_now[b]),
      .i_ap_twr    (twr_by_rd[b] || twr_by_wr[b]),
      .o_open      (O_BANK_OPEN[b]),
      .o_ap_pend   (O_AP_PEND[b]),
      .o_pre_start (O_PRE_START[b])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_cs_nop;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (I_PINS.cs_n && !bst_act) |=> !O_ACC.wr && !O_ACC.rd && $stable(mode);
  endproperty
  a_cs_nop: assert property (p_cs_nop) else $error("deselected command acted on");

  property p_single_wr;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_wr && wb_single) ##1 !new_acc |=> !O_ACC.wr;
  endproperty
  a_single_wr: assert property (p_single_wr) else $error("write burst longer than one");

  property p_rd_burst4;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_rd && bl_code == sdc_pkg::BL_4 && cmd == sdc_pkg::CMD_RD)
        ##1 (cmd == sdc_pkg::CMD_NOP)[*4] |-> O_ACC.rd ##1 !O_ACC.rd;
  endproperty
  a_rd_burst4: assert property (p_rd_burst4) else $error("read burst of four wrong length");

  property p_concurrent;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_acc && other_ap) |=> (O_ACC.rd || O_ACC.wr) && O_ACC.bank == $past(I_PINS.ba);
  endproperty
  a_concurrent: assert property (p_concurrent) else $error("access to other bank refused");

  property p_rd_cl2;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_rd && !cl3 && I_PINS.dqm == 2'h0) ##1 (!kill_out && dqm_q == 2'h0)
        |=> O_DQ_OE == 2'h3 && O_DQ == $past(I_ACC_RDATA);
  endproperty
  a_rd_cl2: assert property (p_rd_cl2) else $error("read data not one latency later");

  property p_rr_pre;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_rd && other_ap && !bst_wr && O_AP_PEND[bst_bank]) |-> O_PRE_START[bst_bank];
  endproperty
  a_rr_pre: assert property (p_rr_pre) else $error("read-read precharge late");

  property p_wr_cut_rd;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_wr && (rdv_q || O_ACC.rd)) |=> O_DQ_OE == 2'h0 ##1 !$past(O_ACC.rd);
  endproperty
  a_wr_cut_rd: assert property (p_wr_cut_rd) else $error("read output after write");

  property p_twr_rd;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (twr_by_rd != 4'h0 && (twr_by_rd & O_AP_PEND) == twr_by_rd && !(|ap_set))
        |-> ##TWR_D ((O_PRE_START & $past(twr_by_rd, TWR_D)) == $past(twr_by_rd, TWR_D));
  endproperty
  a_twr_rd: assert property (p_twr_rd) else $error("precharge not at recovery after read");

  property p_last_wr_rd;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      new_rd |=> !O_ACC.wr && O_ACC.rd;
  endproperty
  a_last_wr_rd: assert property (p_last_wr_rd) else $error("write beat after read");

  property p_twr_wr;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (twr_by_wr != 4'h0 && (twr_by_wr & O_AP_PEND) == twr_by_wr && !(|ap_set))
        |-> ##TWR_D ((O_PRE_START & $past(twr_by_wr, TWR_D)) == $past(twr_by_wr, TWR_D));
  endproperty
  a_twr_wr: assert property (p_twr_wr) else $error("precharge not at recovery after write");

  property p_last_wr_wr;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (new_wr && bst_act && bst_wr) |=> O_ACC.wr && O_ACC.bank == $past(I_PINS.ba)
        && O_ACC.wdata == $past(I_DQ);
  endproperty
  a_last_wr_wr: assert property (p_last_wr_wr) else $error("old write beat kept");

  property p_init_hiz;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (cmd == sdc_pkg::CMD_LMR || cmd == sdc_pkg::CMD_REF) |=> O_DQ_OE == 2'h0;
  endproperty
  a_init_hiz: assert property (p_init_hiz) else $error("outputs driven after init command");

  property p_idle_bank;
    @(posedge I_MCLK) disable iff (!I_RST_N)
      (cmd == sdc_pkg::CMD_RD && !O_BANK_OPEN[I_PINS.ba] && !bst_act) |=> !O_ACC.rd;
  endproperty
  a_idle_bank: assert property (p_idle_bank) else $error("read to idle bank served");
endmodule

// >>> sdc_ctl_model.sv
/*
  Memory controller model: drives the command pins and write data, and
  holds the storage array that answers the sequencer's beats.
  Assumes one shared clock and that the bench calls cmd once per cycle.
*/
`timescale 1ns/100ps
module sdc_ctl_model (
  input  wire logic              i_clk,
  input  wire sdc_pkg::sdc_acc_t i_acc,
  output sdc_pkg::sdc_pins_t     o_pins,
  output logic [15:0]            o_dq,
  output logic [15:0]            o_rdata
);
  logic [15:0] mem [0:1023];
  int          k;

  ////////////////////////////////////////////////////////////////////////////
  // Each word starts as a pattern of its own bank and column
  initial begin
    o_pins = 20'hF0000;
    o_dq   = 16'h0000;
    for (k = 0; k < 1024; k++) begin
      mem[k] = {4'hA, 2'h0, k[9:0]};
    end
  end

  assign o_rdata = mem[{i_acc.bank, i_acc.col}];

  always @(posedge i_clk) begin
    if (i_acc.wr === 1'b1) begin
      if (!i_acc.wmask[0]) begin
        mem[{i_acc.bank, i_acc.col}][7:0] <= i_acc.wdata[7:0];
      end
      if (!i_acc.wmask[1]) begin
        mem[{i_acc.bank, i_acc.col}][15:8] <= i_acc.wdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Caller addresses activated banks only (sc_cs also reads an idle one), masks reads two clocks ahead of
  // an interrupting write, waits before reuse of a precharged bank and may
  // load the mode before refresh
  task automatic cmd(input logic cs_n, input logic [2:0] rcw, input logic [1:0] ba,
                     input logic [11:0] addr, input logic [1:0] dqm,
                     input logic [15:0] dq);
    @(posedge i_clk);
    #1;
    o_pins = {cs_n, rcw, ba, addr, dqm};
    o_dq   = dq;
  endtask
endmodule

// >>> sdc_core_test.sv
/*
  Self-checking bench for the bank sequencer with concurrent precharge.
  Assumes the controller model drives pins 1 ns after each rising edge.
*/
`timescale 1ns/100ps
module sdc_core_test;
  localparam int         TMO = 1500;
  localparam logic [2:0] ACT = 3'b011;
  localparam logic [2:0] RD  = 3'b101;
  localparam logic [2:0] WR  = 3'b100;
  localparam logic [2:0] NOP = 3'b111;

  logic               clk;
  logic               rst_n;
  sdc_pkg::sdc_pins_t pins;
  sdc_pkg::sdc_acc_t  acc;
  logic [15:0]        dq_in;
  logic [15:0]        rdata;
  logic [15:0]        dq_out;
  logic [1:0]         dq_oe;
  logic [3:0]         bank_open;
  logic [3:0]         ap_pend;
  logic [3:0]         pre_start;
  int                 err_total;
  int                 n_compared;
  int                 cyc;
  logic [15:0]        dq_log [0:2047];
  logic [1:0]         oe_log [0:2047];
  logic [3:0]         ps_log [0:2047];
  logic [3:0]         ap_log [0:2047];
  sdc_pkg::sdc_acc_t  acc_log [0:2047];

  sdc_core uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_PINS(pins), .I_DQ(dq_in),
    .I_ACC_RDATA(rdata), .O_ACC(acc), .O_DQ(dq_out), .O_DQ_OE(dq_oe),
    .O_BANK_OPEN(bank_open), .O_AP_PEND(ap_pend), .O_PRE_START(pre_start));

  sdc_ctl_model u_ctl (.i_clk(clk), .i_acc(acc), .o_pins(pins), .o_dq(dq_in),
    .o_rdata(rdata));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle log sampled mid-cycle, where everything has settled
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      err_total++;
      stop_test();
    end
  end

  always @(negedge clk) begin
    if (cyc < 2048) begin
      dq_log[cyc]  = dq_out;
      oe_log[cyc]  = dq_oe;
      ps_log[cyc]  = pre_start;
      ap_log[cyc]  = ap_pend;
      acc_log[cyc] = acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] wd(input logic [1:0] b, input logic [7:0] c);
    wd = {4'hA, 2'h0, b, c};
  endfunction

  // Idle data bus changes every cycle so stale values never pass
  task automatic nop(input int n);
    repeat (n) u_ctl.cmd(1'b0, NOP, 2'h0, 12'h000, 2'h0, 16'hC3C3 ^ cyc[15:0]);
  endtask

  task automatic go(input logic [2:0] rcw, input logic [1:0] ba, input logic [11:0] addr,
                    input logic [1:0] dqm, input logic [15:0] dq, output int k);
    u_ctl.cmd(1'b0, rcw, ba, addr, dqm, dq);
    k = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_init();
    int k;
    chk(16'(bank_open), 16'h0, "open after reset");
    chk(16'(ap_pend), 16'h0, "pending after reset");
    go(3'b000, 2'h0, 12'h022, 2'h0, 16'h0, k);
    go(3'b001, 2'h0, 12'h000, 2'h0, 16'h0, k);
    nop(2);
    chk(16'(oe_log[k + 1]), 16'h0, "outputs after refresh");
  endtask

  task automatic sc_read(input logic [11:0] mode, input logic [1:0] b, input logic [7:0] col);
    int k;
    int i;
    int l;
    logic [7:0] c;
    // Data appears CAS latency cycles after the READ edge
    l = (mode[6:4] == 3'h3) ? 3 : 2;
    go(3'b000, 2'h0, mode, 2'h0, 16'h0, k);
    go(ACT, b, 12'h000, 2'h0, 16'h0, k);
    nop(1);
    go(RD, b, {4'h0, col}, 2'h0, 16'h0, k);
    nop(8);
    for (i = 0; i < 4; i++) begin
      c = mode[3] ? {col[7:2], col[1:0] ^ i[1:0]} : {col[7:2], col[1:0] + i[1:0]};
      chk(16'(acc_log[k + 1 + i].col), 16'(c), "read column");
      chk(dq_log[k + l + i], wd(b, c), "read data");
      chk(16'(oe_log[k + l + i]), 16'h3, "read enable");
    end
    chk(16'(acc_log[k + 5].rd), 16'h0, "burst length");
    chk(16'(oe_log[k + l + 4]), 16'h0, "enable after burst");
  endtask

  task automatic sc_single_wr();
    int k;
    go(3'b000, 2'h0, 12'h222, 2'h0, 16'h0, k);
    go(ACT, 2'h1, 12'h000, 2'h0, 16'h0, k);
    nop(1);
    go(WR, 2'h1, 12'h008, 2'h0, 16'h1111, k);
    u_ctl.cmd(1'b0, NOP, 2'h0, 12'h000, 2'h0, 16'h2222);
    nop(3);
    chk(16'(acc_log[k + 1].wr), 16'h1, "single write beat");
    chk(16'(acc_log[k + 2].wr), 16'h0, "no second beat");
    chk(u_ctl.mem[{2'h1, 8'h08}], 16'h1111, "single write data");
    chk(u_ctl.mem[{2'h1, 8'h09}], wd(2'h1, 8'h09), "next column kept");
    sc_read(12'h222, 2'h1, 8'h0C);
  endtask

  // Auto-precharge read on bank 0 cut by an access to bank 1
  task automatic sc_rd_int(input logic to_wr);
    int k;
    logic [1:0] m;
    m = to_wr ? 2'h3 : 2'h0;
    go(3'b000, 2'h0, 12'h023, 2'h0, 16'h0, k);
    go(ACT, 2'h0, 12'h000, 2'h0, 16'h0, k);
    go(ACT, 2'h1, 12'h000, 2'h0, 16'h0, k);
    nop(1);
    go(RD, 2'h0, 12'h400, 2'h0, 16'h0, k);
    u_ctl.cmd(1'b0, NOP, 2'h0, 12'h000, m, 16'h0);
    u_ctl.cmd(1'b0, NOP, 2'h0, 12'h000, m, 16'h0);
    go(to_wr ? WR : RD, 2'h1, 12'h010, 2'h0, 16'h7E7E, k);
    nop(7);
    chk(16'(ap_log[k - 1][0]), 16'h1, "pending set");
    chk(16'(ps_log[k - 1][0]), 16'h0, "early precharge");
    chk(16'(ps_log[k][0]), 16'h1, "precharge at cut");
    chk(16'(ap_log[k + 2][0]), 16'h0, "pending cleared");
    chk(16'(bank_open[0]), 16'h0, "bank idle");
    chk(16'(acc_log[k + 1].bank), 16'h1, "other bank taken");
    if (to_wr) begin
      chk(16'(acc_log[k + 1].wr), 16'h1, "write taken");
      chk(16'(oe_log[k]), 16'h0, "masked before write");
      chk(16'(oe_log[k + 1]), 16'h0, "read cut by write");
    end else begin
      chk(dq_log[k + 1], wd(2'h0, 8'h02), "old burst until latency");
      chk(dq_log[k + 2], wd(2'h1, 8'h10), "new burst after latency");
    end
  endtask

  // Auto-precharge write on bank 2 cut by an access to bank 3
  task automatic sc_wr_int(input logic to_rd);
    int k;
    int t;
    t = sdc_pkg::TWR_CYC;
    go(3'b000, 2'h0, 12'h023, 2'h0, 16'h0, k);
    go(ACT, 2'h2, 12'h000, 2'h0, 16'h0, k);
    go(ACT, 2'h3, 12'h000, 2'h0, 16'h0, k);
    nop(1);
    go(WR, 2'h2, 12'h400, 2'h0, 16'h0D00, k);
    u_ctl.cmd(1'b0, NOP, 2'h0, 12'h000, 2'h0, 16'h0D01);
    go(to_rd ? RD : WR, 2'h3, 12'h030, 2'h0, 16'h0D02, k);
    nop(6);
    chk(u_ctl.mem[{2'h2, 8'h01}], 16'h0D01, "last data kept");
    chk(u_ctl.mem[{2'h2, 8'h02}], wd(2'h2, 8'h02), "cut beat dropped");
    chk(16'(ps_log[k + t - 1][2]), 16'h0, "precharge too early");
    chk(16'(ps_log[k + t][2]), 16'h1, "precharge after recovery");
    chk(16'(bank_open[2]), 16'h0, "bank idle");
    if (to_rd) begin
      chk(dq_log[k + 2], wd(2'h3, 8'h30), "read after latency");
    end else begin
      chk(u_ctl.mem[{2'h3, 8'h30}], 16'h0D02, "new write data");
    end
  endtask

  task automatic sc_cs();
    int k;
    go(RD, 2'h0, 12'h000, 2'h0, 16'h0, k);
    nop(2);
    chk(16'(acc_log[k + 1].rd), 16'h0, "read to idle bank");
    go(ACT, 2'h0, 12'h000, 2'h0, 16'h0, k);
    nop(2);
    u_ctl.cmd(1'b1, RD, 2'h0, 12'h000, 2'h0, 16'h0);
    k = cyc;
    u_ctl.cmd(1'b1, ACT, 2'h2, 12'h000, 2'h0, 16'h0);
    nop(3);
    chk(16'(acc_log[k + 1].rd), 16'h0, "deselected read");
    chk(16'(oe_log[k + 2]), 16'h0, "deselected output");
    chk(16'(bank_open[2]), 16'h0, "deselected activate");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n      = 1'b0;
    err_total  = 0;
    n_compared = 0;
    cyc        = 0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    sc_init();
    sc_read(12'h022, 2'h0, 8'h04);
    sc_read(12'h02A, 2'h0, 8'h05);
    sc_read(12'h032, 2'h0, 8'h06);
    sc_single_wr();
    sc_rd_int(1'b0);
    sc_rd_int(1'b1);
    sc_wr_int(1'b1);
    sc_wr_int(1'b0);
    sc_cs();
    stop_test();
  end
endmodule
